// ==== verilog/pcct_pkg.sv ====
// Package for the PC Card cycle timing generator: register map,
// window configuration layout and the clock counts of each phase.
// Assumes one 50 MHz system clock drives every user of it.
package pcct_pkg;

   ////////////////////////////////////////////////////////////////////////
   // Register map, byte addresses on the plain register port
   localparam int ADDR_W = 8;
   localparam logic [ADDR_W-1:0] WIN_CFG_BASE = 8'h00;
   localparam logic [ADDR_W-1:0] STATUS_ADDR = 8'h20;
   localparam logic [ADDR_W-1:0] LAST_ACTIVE_ADDR = 8'h24;

   // Window configuration field positions
   localparam int WAIT_SEL_LSB = 0;
   localparam int ZWS_BIT = 2;
   localparam int WIDTH16_BIT = 3;
   localparam int IS_IO_BIT = 4;
   localparam int TSET_LSB = 5;

   // Window configuration reset values
   localparam logic [1:0] WAIT_SEL_RESET = 2'h0;
   localparam logic [1:0] TSET_RESET = 2'h1;

   ////////////////////////////////////////////////////////////////////////
   // Clock counts, one clock is one sys_clk period
   localparam int CNT_W = 5;
   localparam logic [CNT_W-1:0] SETUP_IO = 5'h03;
   localparam logic [CNT_W-1:0] SETUP_MEM_WS0 = 5'h02;
   localparam logic [CNT_W-1:0] SETUP_MEM_LONG = 5'h04;
   localparam logic [CNT_W-1:0] SETUP_EXTRA = 5'h02;
   localparam logic [CNT_W-1:0] HOLD_IO = 5'h02;
   localparam logic [CNT_W-1:0] HOLD_MEM_WS0 = 5'h02;
   localparam logic [CNT_W-1:0] HOLD_MEM_LONG = 5'h03;
   localparam logic [CNT_W-1:0] HOLD_EXTRA = 5'h01;
   localparam logic [CNT_W-1:0] ACT8_ZWS = 5'h07;
   localparam logic [CNT_W-1:0] ACT8_WS0 = 5'h13;
   localparam logic [CNT_W-1:0] ACT8_WSN = 5'h17;
   localparam logic [CNT_W-1:0] ACT16_IO_WS0 = 5'h07;
   localparam logic [CNT_W-1:0] ACT16_IO_LONG = 5'h0b;
   localparam logic [CNT_W-1:0] ACT16_MEM_ZWS = 5'h05;
   localparam logic [CNT_W-1:0] ACT16_MEM_WS00 = 5'h09;
   localparam logic [CNT_W-1:0] ACT16_MEM_WS01 = 5'h0d;
   localparam logic [CNT_W-1:0] ACT16_MEM_WS10 = 5'h11;
   localparam logic [CNT_W-1:0] ACT16_MEM_WS11 = 5'h17;

   ////////////////////////////////////////////////////////////////////////
   // Types
   typedef struct packed {
      logic [1:0] timing_set_select;
      logic is_io;
      logic width16;
      logic zero_wait;
      logic [1:0] wait_state_select;
   } pcct_win_cfg_type;

   typedef struct packed {
      logic [25:0] addr;
      logic write;
      logic attr;
   } pcct_req_type;

   typedef enum logic [3:0] {
      PH_IDLE = 4'b0001,
      PH_SETUP = 4'b0010,
      PH_ACTIVE = 4'b0100,
      PH_HOLD = 4'b1000
   } pcct_phase_type;

endpackage : pcct_pkg

// ==== verilog/pcct_timing.sv ====
// PC Card cycle timing generator: window configuration registers,
// a cycle request port and the card strobe and address pins.
// Assumes all inputs, card wait included, are synchronous to sys_clk.
//
// Function
// R1 - Setup, strobe active and hold intervals are counted in clock cycles.
// R2 - Counts come from the wait-state settings of the hit window.
// R3 - Every interval meets or slightly exceeds the legacy reference timing.
// R4 - Setup: I/O 3; memory 2 or 4 by upper wait-state bit.
// R5 - Hold: I/O 2; memory 2 or 3 by upper wait-state bit.
// R6 - 8-bit strobe: 19 no wait, 23 any wait, 7 zero-wait.
// R7 - 16-bit I/O strobe: 7 or 11; zero-wait unavailable.
// R8 - 16-bit memory strobe: 9, 13, 17, 23; zero-wait gives 5.
// R9 - Card wait low extends the strobe until wait returns high.
// R10 - Address leads the strobe by setup count plus two clocks.
// R11 - Address and attribute select held hold count plus one clock.
// R12 - Loadable down-counter per phase, counts chosen at cycle start.
`timescale 1ns/1ns

module pcct_timing
   import pcct_pkg::*;
#(
   parameter int NUM_WIN = 4
) (
   input wire logic sys_clk,
   input wire logic rst,
   // Register port
   input wire logic [ADDR_W-1:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   output logic [31:0] reg_rdata,
   // Cycle request port
   input wire logic cyc_req,
   input wire logic [1:0] cyc_win,
   input wire pcct_req_type cyc_info,
   output logic cyc_busy,
   output logic cyc_done,
   // Card side
   input wire logic card_wait_n,
   output logic [25:0] card_addr,
   output logic card_addr_oe,
   output logic card_ce_n,
   output logic card_reg_n,
   output logic card_oe_n,
   output logic card_we_n,
   output logic card_iord_n,
   output logic card_iowr_n
);

   if (NUM_WIN < 1 || NUM_WIN > 4) begin : g_bad_win
      $error("NUM_WIN must be 1 to 4");
   end

   // Windows must not run into the status register
   if (int'(WIN_CFG_BASE) + 4 * NUM_WIN > int'(STATUS_ADDR)) begin : g_bad_map
      $error("window registers overlap the status register");
   end

   // Every phase load must fit the down-counter, extras included
   if (int'(SETUP_MEM_LONG) + int'(SETUP_EXTRA) > 2 ** CNT_W) begin : g_bad_setup
      $error("setup count too wide for the counter");
   end
   if (int'(HOLD_MEM_LONG) + int'(HOLD_EXTRA) > 2 ** CNT_W) begin : g_bad_hold
      $error("hold count too wide for the counter");
   end
   // A zero strobe count would wrap the counter to its longest load
   if (ACT16_MEM_ZWS == '0 || ACT8_ZWS == '0) begin : g_bad_active
      $error("strobe count must be at least one clock");
   end

   ////////////////////////////////////////////////////////////////////////
   // Count selection
   function automatic logic [CNT_W-1:0] setup_count(input pcct_win_cfg_type c);
      if (c.is_io) begin
         return SETUP_IO; // R4
      end
      return c.wait_state_select[1] ? SETUP_MEM_LONG : SETUP_MEM_WS0; // R4
   endfunction : setup_count

   function automatic logic [CNT_W-1:0] hold_count(input pcct_win_cfg_type c);
      if (c.is_io) begin
         return HOLD_IO; // R5
      end
      return c.wait_state_select[1] ? HOLD_MEM_LONG : HOLD_MEM_WS0; // R5
   endfunction : hold_count

   // I/O windows carry one wait-state bit, the low one
   function automatic logic [CNT_W-1:0] active_count(input pcct_win_cfg_type c);
      logic any_wait;
      any_wait = c.is_io ? c.wait_state_select[0] : |c.wait_state_select;
      if (!c.width16) begin
         if (any_wait) begin
            return ACT8_WSN; // R6
         end
         return c.zero_wait ? ACT8_ZWS : ACT8_WS0; // R6
      end
      if (c.is_io) begin
         // Zero-wait ignored on 16-bit I/O
         return c.wait_state_select[0] ? ACT16_IO_LONG : ACT16_IO_WS0; // R7
      end
      unique case (c.wait_state_select)
         2'b00: return c.zero_wait ? ACT16_MEM_ZWS : ACT16_MEM_WS00; // R8
         2'b01: return ACT16_MEM_WS01; // R8
         2'b10: return ACT16_MEM_WS10; // R8
         2'b11: return ACT16_MEM_WS11; // R8
      endcase
   endfunction : active_count

   ////////////////////////////////////////////////////////////////////////
   // State
   typedef struct packed {
      pcct_win_cfg_type [NUM_WIN-1:0] win;
      pcct_phase_type phase;
      logic [CNT_W-1:0] cnt;
      logic [CNT_W-1:0] hold_load;
      logic [CNT_W-1:0] last_active;
      logic [7:0] wait_ext;
      pcct_win_cfg_type cur;
      logic cur_write;
      logic [31:0] rdata;
      logic busy;
      logic done;
      logic [25:0] addr;
      logic addr_oe;
      logic ce_n;
      logic reg_n;
      logic oe_n;
      logic we_n;
      logic iord_n;
      logic iowr_n;
   } pcct_state_type;

   pcct_state_type st;
   pcct_state_type next_st;

   logic [ADDR_W-1:0] win_addr [NUM_WIN];

   // Windows sit four bytes apart from the base
   for (genvar i = 0; i < NUM_WIN; i++) begin : g_win_addr
      assign win_addr[i] = WIN_CFG_BASE + ADDR_W'(4 * i);
   end

   ////////////////////////////////////////////////////////////////////////
   // Next state
   always_comb begin
      pcct_win_cfg_type sel;
      logic [CNT_W-1:0] act;
      logic [31:0] rd;
      sel = st.win[0];
      act = '0;
      rd = 32'h0000_0000;
      next_st = st;
      next_st.done = 1'b0;

      // Register writes; configuration is sampled only at cycle start
      for (int i = 0; i < NUM_WIN; i++) begin
         if (reg_write && reg_addr == win_addr[i]) begin
            next_st.win[i] = reg_wdata[TSET_LSB+1:WAIT_SEL_LSB];
         end
         if (reg_addr == win_addr[i]) begin
            rd = {25'h000_0000, st.win[i]};
         end
      end
      if (reg_addr == STATUS_ADDR) begin
         rd = {16'h0000, st.wait_ext, st.phase, 3'h0, st.busy};
      end
      if (reg_addr == LAST_ACTIVE_ADDR) begin
         rd = {27'h000_0000, st.last_active};
      end
      // Read data stands only in the cycle after the strobe
      next_st.rdata = reg_read ? rd : 32'h0000_0000;

      for (int i = 0; i < NUM_WIN; i++) begin
         if (cyc_win == 2'(i)) begin
            sel = st.win[i]; // R2
         end
      end

      unique case (st.phase)
         PH_IDLE: begin
            // Requests while busy are not seen: this phase only takes them
            if (cyc_req) begin
               next_st.phase = PH_SETUP;
               next_st.cur = sel; // R12
               next_st.cur_write = cyc_info.write;
               // Setup load includes the two extra clocks before the strobe
               next_st.cnt = setup_count(sel) + SETUP_EXTRA - 5'h01; // R10
               // Hold load kept aside so the strobe end needs no second decode
               next_st.hold_load = hold_count(sel) + HOLD_EXTRA - 5'h01; // R11
               next_st.busy = 1'b1;
               next_st.addr = cyc_info.addr;
               next_st.addr_oe = 1'b1;
               next_st.ce_n = 1'b0;
               next_st.reg_n = ~cyc_info.attr;
               next_st.wait_ext = 8'h00;
            end
         end
         PH_SETUP: begin
            if (st.cnt == '0) begin
               act = active_count(st.cur); // R3
               next_st.phase = PH_ACTIVE;
               next_st.cnt = act - 5'h01; // R1
               next_st.last_active = act;
               next_st.oe_n = st.cur.is_io | st.cur_write;
               next_st.we_n = st.cur.is_io | ~st.cur_write;
               next_st.iord_n = ~st.cur.is_io | st.cur_write;
               next_st.iowr_n = ~st.cur.is_io | ~st.cur_write;
            end else begin
               next_st.cnt = st.cnt - 5'h01; // R1
            end
         end
         PH_ACTIVE: begin
            // Wait is seen only once the count is out; earlier lows do not stretch
            if (st.cnt != '0) begin
               next_st.cnt = st.cnt - 5'h01; // R1
            end else if (!card_wait_n) begin
               // Count saturates so status never wraps on long waits
               if (st.wait_ext != 8'hff) begin
                  next_st.wait_ext = st.wait_ext + 8'h01; // R9
               end
            end else begin
               next_st.phase = PH_HOLD; // R9
               next_st.cnt = st.hold_load; // R11
               next_st.oe_n = 1'b1;
               next_st.we_n = 1'b1;
               next_st.iord_n = 1'b1;
               next_st.iowr_n = 1'b1;
            end
         end
         PH_HOLD: begin
            if (st.cnt == '0) begin
               next_st.phase = PH_IDLE;
               next_st.busy = 1'b0;
               next_st.done = 1'b1;
               next_st.addr_oe = 1'b0;
               next_st.ce_n = 1'b1;
               next_st.reg_n = 1'b1;
            end else begin
               next_st.cnt = st.cnt - 5'h01; // R11
            end
         end
         default: begin
            // Illegal phase code: drop every card signal and wait for a request
            next_st.phase = PH_IDLE;
            next_st.busy = 1'b0;
            next_st.addr_oe = 1'b0;
            next_st.ce_n = 1'b1;
            next_st.reg_n = 1'b1;
            next_st.oe_n = 1'b1;
            next_st.we_n = 1'b1;
            next_st.iord_n = 1'b1;
            next_st.iowr_n = 1'b1;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // Registers
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         for (int i = 0; i < NUM_WIN; i++) begin
            st.win[i].timing_set_select <= TSET_RESET;
            st.win[i].is_io <= 1'b0;
            st.win[i].width16 <= 1'b0;
            st.win[i].zero_wait <= 1'b0;
            st.win[i].wait_state_select <= WAIT_SEL_RESET;
         end
         st.phase <= PH_IDLE;
         st.cnt <= '0;
         st.hold_load <= '0;
         st.last_active <= '0;
         st.wait_ext <= 8'h00;
         st.cur <= '0;
         st.cur_write <= 1'b0;
         st.rdata <= 32'h0000_0000;
         st.busy <= 1'b0;
         st.done <= 1'b0;
         st.addr <= 26'h000_0000;
         st.addr_oe <= 1'b0;
         st.ce_n <= 1'b1;
         st.reg_n <= 1'b1;
         st.oe_n <= 1'b1;
         st.we_n <= 1'b1;
         st.iord_n <= 1'b1;
         st.iowr_n <= 1'b1;
      end else begin
         st <= next_st;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Outputs, all straight from the state flops
   assign reg_rdata = st.rdata;
   assign cyc_busy = st.busy;
   assign cyc_done = st.done;
   assign card_addr = st.addr;
   assign card_addr_oe = st.addr_oe;
   assign card_ce_n = st.ce_n;
   assign card_reg_n = st.reg_n;
   assign card_oe_n = st.oe_n;
   assign card_we_n = st.we_n;
   assign card_iord_n = st.iord_n;
   assign card_iowr_n = st.iowr_n;

endmodule : pcct_timing

// ==== verification/pcct_card_model.sv ====
// Card-side model: answers the strobes with a wait line held low for a set time.
// Assumes strobes are synchronous to sys_clk; wait is pulled up when idle.
`timescale 1ns/1ns
module pcct_card_model (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic [3:0] strobe_n,
   input wire logic [5:0] stall,
   output logic card_wait_n
);
   logic [5:0] cnt;
   always_ff @(posedge sys_clk) begin
      if (rst || &strobe_n) cnt <= 6'h00;
      else cnt <= cnt + 6'h01;
   end
   // Low from strobe fall for stall clocks, so the stretch is exactly predictable
   assign card_wait_n = &strobe_n || cnt >= stall;
endmodule : pcct_card_model

// ==== verification/pcct_monitor.sv ====
// Checker on the cycle and card ports of the timing generator.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ns
module pcct_monitor (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic cyc_req,
   input wire logic cyc_busy,
   input wire logic cyc_done,
   input wire logic card_wait_n,
   input wire logic [25:0] card_addr,
   input wire logic card_addr_oe,
   input wire logic card_ce_n,
   input wire logic card_oe_n,
   input wire logic card_we_n,
   input wire logic card_iord_n,
   input wire logic card_iowr_n
);
   logic [3:0] stb;
   logic st;
   assign stb = {card_oe_n, card_we_n, card_iord_n, card_iowr_n};
   assign st = ~&stb;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);
   ////////////////////////////////////////////////////////////////////////
   start_cycle_a: assert property (cyc_req && !cyc_busy |=> cyc_busy && !card_ce_n)
      else $error("card cycle did not start");
   setup_span_a: assert property ($rose(st) |-> $past(!card_ce_n, 4))
      else $error("address setup too short");
   hold_span_a: assert property ($fell(st) |-> !card_ce_n [*3])
      else $error("address hold too short");
   active_span_a: assert property ($rose(st) |-> st [*5])
      else $error("strobe too short");
   addr_steady_a: assert property (!card_ce_n && $past(!card_ce_n) |-> $stable(card_addr))
      else $error("address moved in cycle");
   strobe_framed_a: assert property (st |-> !card_ce_n && card_addr_oe && cyc_busy)
      else $error("strobe outside address");
   one_strobe_a: assert property ($onehot0(~stb))
      else $error("two strobes at once");
   wait_stretch_a: assert property (st && !card_wait_n |=> st)
      else $error("strobe released under wait");
   done_follows_a: assert property ($fell(cyc_busy) |-> cyc_done ##1 !cyc_done)
      else $error("done pulse wrong");
endmodule : pcct_monitor
bind pcct_timing pcct_monitor u_mon (.sys_clk, .rst, .cyc_req, .cyc_busy, .cyc_done,
   .card_wait_n, .card_addr, .card_addr_oe, .card_ce_n, .card_oe_n, .card_we_n,
   .card_iord_n, .card_iowr_n);

// ==== verification/testbench.sv ====
// Testbench: programs windows, runs card cycles and measures each phase.
// Assumes the card model answers wait; the checker is bound into the design.
`timescale 1ns/1ns
module testbench
   import pcct_pkg::*;
;
   logic sys_clk = 1'b0, rst = 1'b1, reg_write = 1'b0, reg_read = 1'b0, cyc_req = 1'b0;
   logic [ADDR_W-1:0] reg_addr = 8'h00;
   logic [31:0] reg_wdata = 32'h0000_0000, reg_rdata;
   logic [1:0] cyc_win = 2'h0, nwin = 2'h0;
   pcct_req_type cyc_info = '0;
   logic [5:0] stall = 6'h00;
   logic dir = 1'b0;
   logic cyc_busy, cyc_done, card_wait_n, card_addr_oe, card_ce_n, card_reg_n;
   logic card_oe_n, card_we_n, card_iord_n, card_iowr_n;
   logic [25:0] card_addr;
   int fails = 0, n_tests = 0;
   always #10 sys_clk = ~sys_clk;
   pcct_timing #(.NUM_WIN(4)) DUT (.sys_clk, .rst, .reg_addr, .reg_wdata, .reg_write,
      .reg_read, .reg_rdata, .cyc_req, .cyc_win, .cyc_info, .cyc_busy, .cyc_done,
      .card_wait_n, .card_addr, .card_addr_oe, .card_ce_n, .card_reg_n, .card_oe_n,
      .card_we_n, .card_iord_n, .card_iowr_n);
   pcct_card_model card (.sys_clk, .rst, .stall, .card_wait_n,
      .strobe_n({card_oe_n, card_we_n, card_iord_n, card_iowr_n}));
   ////////////////////////////////////////////////////////////////////////
   task chk(input logic [31:0] g, input logic [31:0] e);
      n_tests++;
      if (g !== e) begin
         fails++;
         $display("BAD %0t got %h exp %h", $time, g, e);
      end
   endtask : chk
   task wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_write <= 1'b1;
      @(posedge sys_clk);
      reg_write <= 1'b0;
   endtask : wr
   task rd(input logic [7:0] a, input logic [31:0] e);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_read <= 1'b1;
      @(posedge sys_clk);
      reg_read <= 1'b0;
      @(negedge sys_clk);
      chk(reg_rdata, e);
   endtask : rd
   // k = {io, width16, zero_wait}; window and direction rotate per call
   task cc(input logic [2:0] k, input logic [1:0] wsel, input int act);
      int s, a, h, g;
      logic [3:0] seen, want;
      logic [25:0] ad;
      logic bad, at;
      s = 0;
      a = 0;
      h = 0;
      seen = 4'hf;
      bad = 1'b0;
      at = k[2] | dir;
      want = ~(4'h8 >> {k[2], dir});
      ad = {nwin, 24'h5a_a5c3} ^ {26{dir}};
      wr({4'h0, nwin, 2'h0}, {25'h0, 2'h1, k, wsel});
      @(posedge sys_clk);
      cyc_req <= 1'b1;
      cyc_win <= nwin;
      cyc_info <= {ad, dir, at};
      @(posedge sys_clk);
      cyc_req <= 1'b0;
      for (g = 0; g < 200; g++) begin
         @(negedge sys_clk);
         if (cyc_busy !== 1'b1) break;
         seen = seen & {card_oe_n, card_we_n, card_iord_n, card_iowr_n};
         if (card_addr !== ad || card_reg_n !== ~at || card_ce_n !== 1'b0) bad = 1'b1;
         if (card_addr_oe !== 1'b1) bad = 1'b1;
         if (&{card_oe_n, card_we_n, card_iord_n, card_iowr_n} !== 1'b1) a++;
         else if (a == 0) s++;
         else h++;
      end
      chk(s, (k[2] ? 3 : wsel[1] ? 4 : 2) + 2);
      chk(a, act > stall ? act : stall + 1);
      chk(h, (k[2] ? 2 : wsel[1] ? 3 : 2) + 1);
      chk(seen, want);
      chk(bad, 1'b0);
      chk(cyc_done, 1'b1);
      chk({card_addr_oe, card_ce_n, card_reg_n}, 32'h0000_0003);
      nwin++;
      dir = ~dir;
   endtask : cc
   ////////////////////////////////////////////////////////////////////////
   task t_regs;
      rd(STATUS_ADDR, 32'h0000_0010);
      rd(WIN_CFG_BASE, 32'h0000_0020);
      wr(8'h30, 32'hffff_ffff);
      rd(8'h30, 32'h0000_0000);
   endtask : t_regs
   task t_act8;
      cc(3'h4, 2'h0, 19);
      cc(3'h4, 2'h1, 23);
      cc(3'h5, 2'h0, 7);
      cc(3'h0, 2'h0, 19);
      cc(3'h0, 2'h1, 23);
      cc(3'h1, 2'h2, 23);
      cc(3'h0, 2'h3, 23);
      cc(3'h1, 2'h0, 7);
   endtask : t_act8
   task t_io16;
      cc(3'h6, 2'h0, 7);
      cc(3'h7, 2'h1, 11);
      cc(3'h7, 2'h0, 7);
   endtask : t_io16
   task t_mem16;
      cc(3'h2, 2'h0, 9);
      cc(3'h3, 2'h1, 13);
      cc(3'h2, 2'h2, 17);
      cc(3'h2, 2'h3, 23);
      cc(3'h3, 2'h0, 5);
   endtask : t_mem16
   task t_wait;
      stall = 6'h09;
      cc(3'h2, 2'h0, 9);
      rd(STATUS_ADDR, 32'h0000_0110);
      rd(LAST_ACTIVE_ADDR, 32'h0000_0009);
      stall = 6'h0c;
      cc(3'h6, 2'h1, 11);
      rd(STATUS_ADDR, 32'h0000_0210);
      rd(LAST_ACTIVE_ADDR, 32'h0000_000b);
      stall = 6'h00;
   endtask : t_wait
   task tally_and_finish;
      $display("tests %0d fails %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : tally_and_finish
   initial begin
      repeat (6) @(posedge sys_clk);
      rst <= 1'b0;
      t_regs;
      t_act8;
      t_io16;
      t_mem16;
      t_wait;
      tally_and_finish;
   end
   initial begin
      repeat (20000) @(posedge sys_clk);
      fails++;
      tally_and_finish;
   end
endmodule : testbench
